// ===== rx_fifo_pkg.sv
// package: register map, field positions and reset values of the receive buffer
`default_nettype none
package rx_fifo_pkg;
	// register word indices; the byte address on the bus is four times the index
	localparam logic [15:0] pop_data_off = 16'h2080;
	localparam logic [15:0] write_pointer_off = 16'h2081;
	localparam logic [15:0] read_pointer_off = 16'h2082;
	localparam logic [15:0] control_off = 16'h2083;
	localparam logic [15:0] status_off = 16'h2084;
	localparam logic [15:0] fill_count_off = 16'h2085;
	localparam logic [15:0] remaining_off = 16'h2086;
	localparam logic [15:0] decrypt_start_off = 16'h2087;
	localparam logic [15:0] decrypt_length_off = 16'h2088;
	localparam logic [15:0] irq_status_off = 16'h2089;
	localparam logic [15:0] irq_mask_off = 16'h208a;
	localparam int clr_bit = 0;
	localparam int ena_bit = 1;
	localparam int asa_bit = 2;
	localparam int wp_msb_bit = 7;
	localparam int rp_msb_bit = 6;
	localparam int full_bit = 1;
	localparam int empty_bit = 0;
	localparam int ev_full_bit = 0;
	localparam int ev_packet_bit = 1;
	localparam int ev_overflow_bit = 2;
	localparam int ev_underflow_bit = 3;
	localparam logic [7:0] control_reset = 8'h06;
	localparam logic [7:0] byte_zero = 8'h00;
	localparam logic [3:0] irq_zero = 4'h0;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word = 3'h2;
endpackage
`default_nettype wire

// ===== rx_fifo_mem.sv
// storage: byte-wide buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_mem #(
	parameter int addr_w = 8
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [addr_w-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// read port
	input wire logic [addr_w-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:(1<<addr_w)-1];

	// no reset on the array so it maps to ram
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // rx_fifo_mem
`default_nettype wire

// ===== mac_rx_fifo_control.sv
// receive buffer control: pointers, flags, cipher window and ahb-lite registers
//
// Behaviour
// - a pop data register hands out the bytes stored in the 256-byte buffer to mcu or dma.
// - a 9-bit write pointer, low byte in its own register and msb in status bit 7, counts stored bytes.
// - a 9-bit read pointer, low byte in its own register and msb in status bit 6, counts removed bytes.
// - the pointer msbs tell a full buffer from an empty one when the low bytes match.
// - status bit 1 reads one exactly when 256 bytes are held.
// - status bit 0 reads one exactly when no byte is held.
// - the fill count register reads write pointer minus read pointer.
// - writing one to control bit 0 resets pointers, status, count and remaining count.
// - the buffer works only while control bit 1 is one, which it is after reset.
// - while control bit 2 is one each received packet loads the decryption start and length.
// - the decryption start register is written by the mcu or loaded by auto-set.
// - the decryption length register is written by the mcu or loaded by auto-set.
`timescale 1ns/1ps
`default_nettype none
module mac_rx_fifo_control #(
	parameter int addr_w = 8
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// receive path byte stream, same clock domain
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte_data,
	input wire logic rx_packet_start,
	input wire logic rx_packet_end,
	// receive dma channel pop port
	input wire logic dma_pop,
	output logic [7:0] dma_pop_data,
	output logic dma_pop_valid,
	// cipher window handed to the decryption engine
	output logic [7:0] decrypt_start,
	output logic [7:0] decrypt_length,
	// interrupt
	output logic irq
);
	logic [addr_w:0] wp_q;
	logic [addr_w:0] rp_q;
	logic [7:0] ctl_q;
	logic [7:0] start_q;
	logic [7:0] length_q;
	logic [7:0] pkt_base_q;
	logic [7:0] pkt_len_q;
	logic [7:0] remain_q;
	logic [3:0] irq_sts_q;
	logic [3:0] irq_mask_q;
	logic wr_phase_q;
	logic rd_phase_q;
	logic [15:0] addr_q;
	logic [7:0] rd_data;
	logic [31:0] hrdata_q;
	logic pop_pend_q;
	logic dma_pend_q;
	logic dma_valid_q;
	logic [7:0] dma_data_q;
	logic irq_q;

	logic full;
	logic empty;
	logic [addr_w:0] used;
	logic push;
	logic pop;
	logic bus_pop;
	logic addr_ok;
	logic do_clear;
	logic [3:0] ev;
	logic [7:0] sts_byte;
	logic [7:0] wdat;
	logic [31:0] rdmux;
	logic [15:0] bus_index;
	logic [7:0] pkt_base_cur;
	logic [7:0] pkt_len_cur;

	// bus decode: only whole-word transfers are accepted; a narrower size is ignored
	// rather than refused, since the slave only ever answers okay
	assign addr_ok = hsel && hready && (htrans == rx_fifo_pkg::htrans_nonseq) &&
		(hsize == rx_fifo_pkg::hsize_word);
	assign wdat = hwdata[7:0];
	// one aligned word per register: the map index is the byte address over four
	assign bus_index = {2'b00, haddr[15:2]};

	// occupancy from the 9-bit pointers; msb difference marks a wrapped buffer
	assign used = wp_q - rp_q;
	assign full = (wp_q[addr_w] != rp_q[addr_w]) &&
		(wp_q[addr_w-1:0] == rp_q[addr_w-1:0]);
	assign empty = (wp_q == rp_q);

	assign sts_byte = {wp_q[addr_w], rp_q[addr_w], 4'h0, full, empty};

	// bus read of the pop register removes a byte; dma pops share the same pointer
	assign bus_pop = addr_ok && !hwrite && (bus_index == rx_fifo_pkg::pop_data_off);
	assign pop = (bus_pop || dma_pop) && !empty && ctl_q[rx_fifo_pkg::ena_bit];
	assign push = rx_byte_valid && !full && ctl_q[rx_fifo_pkg::ena_bit];
	assign do_clear = wr_phase_q && (addr_q == rx_fifo_pkg::control_off) &&
		wdat[rx_fifo_pkg::clr_bit];

	// hardware events for the interrupt status
	always_comb begin
		ev = rx_fifo_pkg::irq_zero;
		ev[rx_fifo_pkg::ev_full_bit] = push && (used == (addr_w+1)'((1 << addr_w) - 1));
		ev[rx_fifo_pkg::ev_packet_bit] = rx_packet_end;
		ev[rx_fifo_pkg::ev_overflow_bit] = rx_byte_valid && full;
		ev[rx_fifo_pkg::ev_underflow_bit] = (bus_pop || dma_pop) && empty;
	end

	// buffer storage; read address is the current read pointer
	rx_fifo_mem #(
		.addr_w(addr_w)
	) u_mem (
		.clk(hclk),
		.wr_en(push),
		.wr_addr(wp_q[addr_w-1:0]),
		.wr_data(rx_byte_data),
		.rd_addr(rp_q[addr_w-1:0]),
		.rd_data(rd_data)
	);

	// bus address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase_q <= 1'b0;
			rd_phase_q <= 1'b0;
			addr_q <= 16'h0000;
		end else begin
			wr_phase_q <= addr_ok && hwrite;
			rd_phase_q <= addr_ok && !hwrite;
			if (addr_ok) begin
				addr_q <= bus_index;
			end
		end
	end

	// write pointer: counts stored bytes, writable from the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= '0;
		end else if (do_clear) begin
			wp_q <= '0;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::write_pointer_off) begin
			wp_q[addr_w-1:0] <= wdat;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::status_off) begin
			wp_q[addr_w] <= wdat[rx_fifo_pkg::wp_msb_bit];
		end else if (push) begin
			wp_q <= wp_q + 1'b1;
		end
	end

	// read pointer: counts removed bytes, writable from the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rp_q <= '0;
		end else if (do_clear) begin
			rp_q <= '0;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::read_pointer_off) begin
			rp_q[addr_w-1:0] <= wdat;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::status_off) begin
			rp_q[addr_w] <= wdat[rx_fifo_pkg::rp_msb_bit];
		end else if (pop) begin
			rp_q <= rp_q + 1'b1;
		end
	end

	// control register; clear bit is a strobe and never stays set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_q <= rx_fifo_pkg::control_reset;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::control_off) begin
			ctl_q <= {5'h00, wdat[rx_fifo_pkg::asa_bit], wdat[rx_fifo_pkg::ena_bit], 1'b0};
		end
	end

	// packet position and size including this cycle's byte, so a one-byte packet
	// whose start and end fall together still loads its own window
	always_comb begin
		pkt_base_cur = pkt_base_q;
		pkt_len_cur = pkt_len_q;
		if (rx_packet_start) begin
			pkt_base_cur = wp_q[addr_w-1:0];
			pkt_len_cur = rx_fifo_pkg::byte_zero;
		end
		if (push) begin
			pkt_len_cur = pkt_len_cur + 8'h01;
		end
	end

	// track the current packet position and size for auto-set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pkt_base_q <= rx_fifo_pkg::byte_zero;
			pkt_len_q <= rx_fifo_pkg::byte_zero;
		end else begin
			pkt_base_q <= pkt_base_cur;
			pkt_len_q <= pkt_len_cur; // dropped bytes are not counted
		end
	end

	// decryption start: mcu write, or packet base at packet end when auto-set is on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= rx_fifo_pkg::byte_zero;
		end else if (rx_packet_end && ctl_q[rx_fifo_pkg::asa_bit]) begin
			start_q <= pkt_base_cur;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::decrypt_start_off) begin
			start_q <= wdat;
		end
	end

	// decryption length: mcu write, or packet size; a byte in the end cycle is counted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			length_q <= rx_fifo_pkg::byte_zero;
		end else if (rx_packet_end && ctl_q[rx_fifo_pkg::asa_bit]) begin
			length_q <= pkt_len_cur;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::decrypt_length_off) begin
			length_q <= wdat;
		end
	end

	// remaining count: size of the last packet, less one for each later pop, down to zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			remain_q <= rx_fifo_pkg::byte_zero;
		end else if (do_clear) begin
			remain_q <= rx_fifo_pkg::byte_zero;
		end else if (rx_packet_end) begin
			remain_q <= pkt_len_cur;
		end else if (pop && remain_q != rx_fifo_pkg::byte_zero) begin
			remain_q <= remain_q - 8'h01;
		end
	end

	// interrupt status: set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sts_q <= rx_fifo_pkg::irq_zero;
		end else if (wr_phase_q && addr_q == rx_fifo_pkg::irq_status_off) begin
			irq_sts_q <= (irq_sts_q & ~wdat[3:0]) | ev;
		end else begin
			irq_sts_q <= irq_sts_q | ev;
		end
	end

	// interrupt mask and registered interrupt output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= rx_fifo_pkg::irq_zero;
			irq_q <= 1'b0;
		end else begin
			if (wr_phase_q && addr_q == rx_fifo_pkg::irq_mask_off) begin
				irq_mask_q <= wdat[3:0];
			end
			irq_q <= |(irq_sts_q & irq_mask_q);
		end
	end

	// pop tracking: memory data of the popped byte appears one cycle after the pop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pop_pend_q <= 1'b0;
			dma_pend_q <= 1'b0;
		end else begin
			pop_pend_q <= pop && bus_pop;
			dma_pend_q <= pop && !bus_pop;
		end
	end

	// read multiplexer for the data phase
	always_comb begin
		rdmux = 32'h0000_0000;
		unique case (addr_q)
			rx_fifo_pkg::pop_data_off: rdmux[7:0] = pop_pend_q ? rd_data : rx_fifo_pkg::byte_zero;
			rx_fifo_pkg::write_pointer_off: rdmux[7:0] = wp_q[addr_w-1:0];
			rx_fifo_pkg::read_pointer_off: rdmux[7:0] = rp_q[addr_w-1:0];
			rx_fifo_pkg::control_off: rdmux[7:0] = ctl_q;
			rx_fifo_pkg::status_off: rdmux[7:0] = sts_byte;
			rx_fifo_pkg::fill_count_off: rdmux[7:0] = used[7:0];
			rx_fifo_pkg::remaining_off: rdmux[7:0] = remain_q;
			rx_fifo_pkg::decrypt_start_off: rdmux[7:0] = start_q;
			rx_fifo_pkg::decrypt_length_off: rdmux[7:0] = length_q;
			rx_fifo_pkg::irq_status_off: rdmux[3:0] = irq_sts_q;
			rx_fifo_pkg::irq_mask_off: rdmux[3:0] = irq_mask_q;
			default: rdmux = 32'h0000_0000;
		endcase
	end

	// bus answer: one wait state so the popped byte comes out of the memory register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= !(addr_ok && !hwrite);
			if (rd_phase_q) begin
				hrdata_q <= rdmux;
			end
		end
	end

	// dma pop answer and cipher window outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dma_valid_q <= 1'b0;
			dma_data_q <= rx_fifo_pkg::byte_zero;
			decrypt_start <= rx_fifo_pkg::byte_zero;
			decrypt_length <= rx_fifo_pkg::byte_zero;
		end else begin
			dma_valid_q <= dma_pend_q;
			if (dma_pend_q) begin
				dma_data_q <= rd_data;
			end
			decrypt_start <= start_q;
			decrypt_length <= length_q;
		end
	end

	// registered outputs; the slave only ever answers okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;
	assign dma_pop_data = dma_data_q;
	assign dma_pop_valid = dma_valid_q;
	assign irq = irq_q;
endmodule // mac_rx_fifo_control
`default_nettype wire

// ===== mac_rx_fifo_control_asserts.sv
// checker: bus timing and output relations of the receive buffer block
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// stream, dma, window, interrupt
	input wire logic rx_packet_end,
	input wire logic dma_pop,
	input wire logic dma_pop_valid,
	input wire logic [7:0] decrypt_start,
	input wire logic [7:0] decrypt_length,
	input wire logic irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// accepted address phases
	wire logic acc = hsel && hready && htrans == rx_fifo_pkg::htrans_nonseq &&
		hsize == rx_fifo_pkg::hsize_word;
	wire logic wacc = acc && hwrite;
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (acc && !hwrite |=> s_one_wait)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wacc |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	// read data may only move as a read completes
	a_data_stands: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
		else $error("read data moved");
	a_pop_latency: assert property (dma_pop_valid |-> $past(dma_pop, 2))
		else $error("pop answer unasked");
	// window moves only after packet end or a bus write
	a_window_cause: assert property (($changed(decrypt_start) || $changed(decrypt_length))
		|-> $past(rx_packet_end, 2) || $past(wacc, 3))
		else $error("window moved without cause");
	a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !irq && !dma_pop_valid)
		else $error("outputs busy after reset");
endmodule // rx_fifo_checker
bind mac_rx_fifo_control rx_fifo_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hsize, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .rx_packet_end, .dma_pop, .dma_pop_valid,
	.decrypt_start, .decrypt_length, .irq);
`default_nettype wire

// ===== rx_partner.sv
// partner: receive path byte source and receive dma channel
`timescale 1ns/1ps
`default_nettype none
module rx_partner (
	// clock
	input wire logic clk,
	// receive stream
	output logic rx_byte_valid,
	output logic [7:0] rx_byte_data,
	output logic rx_packet_start,
	output logic rx_packet_end,
	// dma channel
	output logic dma_pop,
	input wire logic dma_pop_valid,
	input wire logic [7:0] dma_pop_data
);
	// quiet lines at time zero
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte_data = 8'h00;
		rx_packet_start = 1'b0;
		rx_packet_end = 1'b0;
		dma_pop = 1'b0;
	end
	// one byte a cycle, so bursts arrive back to back
	task automatic send_byte(input logic [7:0] v, input logic first, input logic last);
		rx_byte_valid <= 1'b1;
		rx_byte_data <= v;
		rx_packet_start <= first;
		rx_packet_end <= last;
		@(posedge clk);
	endtask
	// idle data shows the inverse, so a stale byte is never mistaken for new
	task automatic idle();
		rx_byte_valid <= 1'b0;
		rx_byte_data <= ~rx_byte_data;
		rx_packet_start <= 1'b0;
		rx_packet_end <= 1'b0;
		@(posedge clk);
	endtask
	// pop one byte; a missing answer leaves unknown data
	task automatic pop_byte(output logic [7:0] v);
		v = 8'hxx;
		dma_pop <= 1'b1;
		@(posedge clk);
		dma_pop <= 1'b0;
		repeat (4) begin
			@(posedge clk);
			if (dma_pop_valid === 1'b1) v = dma_pop_data;
		end
	endtask
endmodule // rx_partner
`default_nettype wire

// ===== testbench.sv
// testbench: reference model against the receive buffer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [15:0] haddr = 16'h0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, d;
	logic hreadyout, hresp, rbv, rps, rpe, dpop, dval, irq;
	logic [7:0] rbd, dpd, dstart, dlen, b;
	logic [7:0] q[$];
	int n_errors = 0, num_checks = 0, seed = 20, wp = 0, rp = 0, ena = 1;
	always #20 hclk = ~hclk;
	mac_rx_fifo_control u_mac_rx_fifo_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hsize(rx_fifo_pkg::hsize_word), .hwrite(hwrite),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .rx_byte_valid(rbv), .rx_byte_data(rbd), .rx_packet_start(rps),
		.rx_packet_end(rpe), .dma_pop(dpop), .dma_pop_data(dpd), .dma_pop_valid(dval),
		.decrypt_start(dstart), .decrypt_length(dlen), .irq(irq));
	rx_partner u_rx_partner (.clk(hclk), .rx_byte_valid(rbv), .rx_byte_data(rbd),
		.rx_packet_start(rps), .rx_packet_end(rpe), .dma_pop(dpop), .dma_pop_valid(dval),
		.dma_pop_data(dpd));
	// single word transfer; waits on ready, never on a fixed count
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {a[13:0], 2'b00}; // byte address of the register word
		hwrite <= w;
		htrans <= rx_fifo_pkg::htrans_nonseq;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, v};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		bus(1'b1, a, v, d);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, d);
		`CHK(d, {24'h000000, e})
	endtask
	function automatic int cnt();
		return (wp - rp + 512) % 512;
	endfunction
	task automatic regs();
		rd_chk(rx_fifo_pkg::write_pointer_off, wp[7:0]);
		rd_chk(rx_fifo_pkg::read_pointer_off, rp[7:0]);
		rd_chk(rx_fifo_pkg::status_off, {wp[8], rp[8], 4'h0, cnt() == 256, cnt() == 0});
		rd_chk(rx_fifo_pkg::fill_count_off, 8'(cnt()));
	endtask
	// model drops bytes while full or disabled
	task automatic push(input logic first, input logic last);
		b = 8'($random(seed));
		u_rx_partner.send_byte(b, first, last);
		if (ena != 0 && cnt() < 256) begin
			q.push_back(b);
			wp = (wp + 1) % 512;
		end
	endtask
	task automatic pop(input logic dma);
		logic [7:0] e;
		e = 8'h00;
		if (q.size() > 0) begin
			e = q.pop_front();
			rp = (rp + 1) % 512;
		end
		if (dma) begin
			u_rx_partner.pop_byte(b);
		end else begin
			bus(1'b0, rx_fifo_pkg::pop_data_off, 8'h00, d);
			b = d[7:0];
		end
		`CHK(b, e)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog: far beyond the roughly 1450 cycles the tests need
	initial begin
		#400000;
		n_errors++;
		results();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		regs();
		rd_chk(rx_fifo_pkg::control_off, rx_fifo_pkg::control_reset);
		rd_chk(16'h2090, 8'h00);
		$display("reset values done");
		wr(rx_fifo_pkg::irq_mask_off, 8'h02);
		for (int i = 0; i < 5; i++) push(i == 0, i == 4);
		u_rx_partner.idle();
		regs();
		rd_chk(rx_fifo_pkg::decrypt_start_off, 8'h00);
		rd_chk(rx_fifo_pkg::decrypt_length_off, 8'h05);
		`CHK(dlen, 8'h05)
		`CHK(irq, 1'b1)
		wr(rx_fifo_pkg::irq_status_off, 8'h0f);
		repeat (2) @(posedge hclk);
		`CHK(irq, 1'b0)
		wr(rx_fifo_pkg::irq_mask_off, 8'h00);
		for (int i = 0; i < 3; i++) push(i == 0, i == 2);
		u_rx_partner.idle();
		rd_chk(rx_fifo_pkg::decrypt_start_off, 8'h05);
		`CHK(dstart, 8'h05)
		rd_chk(rx_fifo_pkg::remaining_off, 8'h03);
		`CHK(irq, 1'b0)
		$display("auto window and interrupt done");
		for (int i = 0; i < 4; i++) pop(i % 2);
		// 252 bytes fill the buffer, the last two must be dropped
		for (int i = 0; i < 254; i++) push(1'b0, 1'b0);
		u_rx_partner.idle();
		regs();
		while (q.size() > 0) pop(q.size() % 2);
		pop(1'b0);
		regs();
		$display("fill, wrap and drain done");
		wr(rx_fifo_pkg::control_off, 8'h02);
		wr(rx_fifo_pkg::decrypt_start_off, 8'ha5);
		wr(rx_fifo_pkg::decrypt_length_off, 8'h5a);
		push(1'b1, 1'b0);
		push(1'b0, 1'b1);
		u_rx_partner.idle();
		rd_chk(rx_fifo_pkg::decrypt_length_off, 8'h5a);
		`CHK(dstart, 8'ha5)
		wr(rx_fifo_pkg::control_off, 8'h00);
		ena = 0;
		push(1'b1, 1'b1);
		u_rx_partner.idle();
		regs();
		wr(rx_fifo_pkg::control_off, 8'h03);
		ena = 1;
		q.delete();
		wp = 0;
		rp = 0;
		regs();
		rd_chk(rx_fifo_pkg::control_off, 8'h02);
		rd_chk(rx_fifo_pkg::remaining_off, 8'h00);
		$display("manual window, disable and clear done");
		// one-byte packet: start and end in the same cycle as its byte
		wr(rx_fifo_pkg::control_off, 8'h06);
		push(1'b1, 1'b1);
		u_rx_partner.idle();
		rd_chk(rx_fifo_pkg::decrypt_start_off, 8'h00);
		rd_chk(rx_fifo_pkg::decrypt_length_off, 8'h01);
		`CHK(dlen, 8'h01)
		pop(1'b1);
		$display("one-byte packet done");
		results();
	end
endmodule // testbench
`default_nettype wire
